// File: hw/dsrp_params.svh
`ifndef DSRP_PARAMS_SVH
`define DSRP_PARAMS_SVH
// two-wire addressing
`define DSRP_TGT_BASE 7'h50
`define DSRP_TGT_STRAP_MASK 7'h05
`define DSRP_GC_ADDR 7'h00
`define DSRP_GC_RESET 8'h06
`define DSRP_PTR_LAST 7'h7F
`define DSRP_BYTE_BITS 4'h8
// four-wire frame layout
`define DSRP_FRAME_BITS 5'h18
`define DSRP_FRAME_TOP 5'h17
`define DSRP_RW_BIT 23
`define DSRP_ADDR_HI 22
`define DSRP_ADDR_LO 16
`define DSRP_DATA_HI 15
`endif

// File: hw/dsrp_pkg.sv
package dsrp_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_RXACK, ST_TX, ST_TXACK, ST_WAIT} dsrp_st_e;
    typedef enum logic [1:0] {MD_NONE, MD_I2C, MD_SPI} dsrp_mode_e;
endpackage

// File: hw/dsrp_port.sv
`timescale 1ns/100ps
`include "dsrp_params.svh"
module dsrp_port (
    // system
    input wire logic clk,
    input wire logic reset,
    // two-wire link
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap_low,
    input wire logic addr_strap_high,
    // four-wire link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    // configuration and status
    input wire logic readback_output_enable,
    input wire logic output_edge_select,
    input wire logic [6:0] status_low,
    output logic mode_i2c,
    output logic mode_spi,
    output logic sw_reset,
    // register file
    output logic [6:0] reg_addr,
    output logic reg_wr_en,
    output logic [15:0] reg_wr_data,
    input wire logic [15:0] reg_rd_data
);

function automatic logic [6:0] dsrp_tgt(input logic hi, input logic lo);
    dsrp_tgt = `DSRP_TGT_BASE | {4'h0, hi, 1'b0, lo};
endfunction
// ----------------------------------------
// four-wire link, serial clock domain
// ----------------------------------------
logic fresh, spi_tog, next_spi_tog, sdo_bit, sdo_rise, oes_s1, oes_s2, roe_s1, roe_s2;
logic [4:0] spi_cnt, next_spi_cnt;
logic [23:0] spi_sh, next_spi_sh, rb_word, next_rb_word;
dsrp_pkg::dsrp_mode_e mode, next_mode;
// set while chip select is high, so the first falling edge restarts the count
always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
        fresh <= 1'b1;
    end else begin
        fresh <= 1'b0;
    end
end

always_comb begin
    next_spi_sh = spi_sh;
    next_spi_cnt = spi_cnt;
    next_spi_tog = spi_tog;
    if (!cs_n) begin
        next_spi_sh = {spi_sh[22:0], sdi};
        next_spi_tog = fresh ? ~spi_tog : spi_tog;
        next_spi_cnt = fresh ? 5'h01 : (spi_cnt == `DSRP_FRAME_BITS) ? spi_cnt : spi_cnt + 5'h01;
    end
end
always_ff @(negedge sclk or posedge reset) begin
    if (reset) begin
        spi_sh <= 24'h00_0000;
        spi_cnt <= 5'h00;
        spi_tog <= 1'b0;
    end else begin
        spi_sh <= next_spi_sh;
        spi_cnt <= next_spi_cnt;
        spi_tog <= next_spi_tog;
    end
end

// rb_word is only rewritten just after chip select rises, so it is quiet during a frame
assign sdo_bit = fresh ? rb_word[`DSRP_RW_BIT] :
    (spi_cnt >= `DSRP_FRAME_BITS) ? 1'b0 : rb_word[`DSRP_FRAME_TOP - spi_cnt];
always_ff @(posedge sclk) begin
    sdo_rise <= sdo_bit;
end
assign sdo_out = oes_s2 ? sdo_rise : sdo_bit;
assign sdo_oe = !cs_n && roe_s2 && mode == dsrp_pkg::MD_SPI;

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
logic cs_s1, cs_s2, cs_d, tog_s1, tog_s2, a0_s1, a0_s2, a1_s1, a1_s2;
always_ff @(posedge clk) begin
    if (reset) begin
        {scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3F;
        {cs_s1, cs_s2, cs_d, tog_s1, tog_s2} <= 5'h1C;
        {a0_s1, a0_s2, a1_s1, a1_s2} <= 4'h0;
        {roe_s1, roe_s2, oes_s1, oes_s2} <= 4'h0;
    end else begin
        {scl_s1, scl_s2, scl_d} <= {scl, scl_s1, scl_s2};
        {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
        {cs_s1, cs_s2, cs_d} <= {cs_n, cs_s1, cs_s2};
        {tog_s1, tog_s2} <= {spi_tog, tog_s1};
        {a0_s1, a0_s2, a1_s1, a1_s2} <= {addr_strap_low, a0_s1, addr_strap_high, a1_s1};
        {roe_s1, roe_s2} <= {readback_output_enable, roe_s1};
        {oes_s1, oes_s2} <= {output_edge_select, oes_s1};
    end
end
logic scl_rise, scl_fall, i2c_start, i2c_stop, cs_rise, cs_fall;
assign scl_rise = scl_s2 && !scl_d;
assign scl_fall = !scl_s2 && scl_d;
assign i2c_start = scl_s2 && scl_d && sda_d && !sda_s2;
assign i2c_stop = scl_s2 && scl_d && !sda_d && sda_s2;
assign cs_rise = cs_s2 && !cs_d;
assign cs_fall = !cs_s2 && cs_d;

// ----------------------------------------
// protocol engine, system clock domain
// ----------------------------------------
dsrp_pkg::dsrp_st_e st, next_st;
logic [3:0] bitcnt, next_bitcnt;
logic [7:0] shreg, next_shreg, hi_byte, next_hi_byte;
logic [6:0] target, next_target, pointer, next_pointer, next_reg_addr;
logic is_gc, next_is_gc, is_read, next_is_read, first, next_first;
logic hi_wr, next_hi_wr, wr_pend, next_wr_pend, block, next_block;
logic tx_lo, next_tx_lo, drive, next_drive, adv, next_adv;
logic [15:0] word, next_word, next_wr_data;
logic next_wr_en, next_sw_reset, tog_seen, next_tog_seen, spi_cap, next_spi_cap;
always_comb begin
    next_mode = mode;
    next_st = st;
    {next_bitcnt, next_shreg, next_hi_byte, next_target} = {bitcnt, shreg, hi_byte, target};
    {next_pointer, next_reg_addr, next_word, next_wr_data} = {pointer, reg_addr, word, reg_wr_data};
    {next_is_gc, next_is_read, next_first, next_hi_wr} = {is_gc, is_read, first, hi_wr};
    {next_wr_pend, next_block, next_tx_lo, next_drive} = {wr_pend, block, tx_lo, drive};
    {next_adv, next_wr_en, next_sw_reset, next_spi_cap} = 4'h0;
    {next_tog_seen, next_rb_word} = {tog_seen, rb_word};
    if (adv && reg_addr != `DSRP_PTR_LAST) begin
        next_reg_addr = reg_addr + 7'h01;
    end
    if (mode == dsrp_pkg::MD_NONE && cs_fall) begin
        next_mode = dsrp_pkg::MD_SPI;
    end
    if (mode != dsrp_pkg::MD_SPI && i2c_start) begin
        next_mode = dsrp_pkg::MD_I2C;
        next_st = dsrp_pkg::ST_ADDR;
        {next_bitcnt, next_drive} = 5'h00;
        next_target = dsrp_tgt(a1_s2, a0_s2);
    end else if (mode == dsrp_pkg::MD_I2C && i2c_stop) begin
        next_st = dsrp_pkg::ST_IDLE;
        next_drive = 1'b0;
    end else if (mode == dsrp_pkg::MD_I2C) begin
        unique case (st)
            dsrp_pkg::ST_IDLE, dsrp_pkg::ST_WAIT: begin
            end
            dsrp_pkg::ST_ADDR, dsrp_pkg::ST_RX: begin
                if (scl_rise) begin
                    next_shreg = {shreg[6:0], sda_s2};
                    next_bitcnt = bitcnt + 4'h1;
                end else if (scl_fall && bitcnt == `DSRP_BYTE_BITS) begin
                    next_st = dsrp_pkg::ST_RXACK;
                    {next_bitcnt, next_drive} = 5'h01;
                    if (st == dsrp_pkg::ST_ADDR) begin
                        {next_first, next_hi_wr, next_tx_lo} = 3'h6;
                        if (shreg[7:1] == target) begin
                            {next_is_gc, next_is_read} = {1'b0, shreg[0]};
                            next_reg_addr = pointer;
                        end else if (shreg == {`DSRP_GC_ADDR, 1'b0}) begin
                            {next_is_gc, next_is_read} = 2'h2;
                        end else begin
                            next_st = dsrp_pkg::ST_WAIT;
                            next_drive = 1'b0;
                        end
                    end else if (is_gc) begin
                        next_first = 1'b0;
                        next_sw_reset = first && shreg == `DSRP_GC_RESET;
                    end else if (first) begin
                        next_first = 1'b0;
                        next_block = shreg[7];
                        next_pointer = shreg[6:0];
                        next_reg_addr = shreg[6:0];
                    end else if (hi_wr) begin
                        next_hi_byte = shreg;
                        next_hi_wr = 1'b0;
                    end else begin
                        next_hi_wr = 1'b1;
                        next_wr_pend = 1'b1;
                    end
                end
            end
            dsrp_pkg::ST_RXACK: begin
                if (scl_fall) begin
                    next_drive = 1'b0;
                    next_st = (is_gc && !first) ? dsrp_pkg::ST_WAIT : dsrp_pkg::ST_RX;
                    next_wr_pend = 1'b0;
                    next_wr_en = wr_pend;
                    next_wr_data = wr_pend ? {hi_byte, shreg} : reg_wr_data;
                    next_adv = wr_pend && block;
                    if (is_read) begin
                        next_st = dsrp_pkg::ST_TX;
                        next_word = reg_rd_data;
                        next_shreg = reg_rd_data[15:8];
                        next_drive = !reg_rd_data[15];
                    end
                end
            end
            dsrp_pkg::ST_TX: begin
                if (scl_rise) begin
                    next_bitcnt = bitcnt + 4'h1;
                end else if (scl_fall && bitcnt == `DSRP_BYTE_BITS) begin
                    next_st = dsrp_pkg::ST_TXACK;
                    {next_bitcnt, next_drive} = 5'h00;
                end else if (scl_fall) begin
                    next_shreg = {shreg[6:0], 1'b0};
                    next_drive = !shreg[6];
                end
            end
            dsrp_pkg::ST_TXACK: begin
                if (scl_rise) begin
                    if (sda_s2) begin
                        next_st = dsrp_pkg::ST_WAIT;
                    end else if (!tx_lo) begin
                        {next_tx_lo, next_shreg} = {1'b1, word[7:0]};
                    end else begin
                        {next_tx_lo, next_adv} = {1'b0, block};
                    end
                end else if (scl_fall) begin
                    next_st = dsrp_pkg::ST_TX;
                    next_drive = !shreg[7];
                    if (!tx_lo) begin
                        next_word = reg_rd_data;
                        next_shreg = reg_rd_data[15:8];
                        next_drive = !reg_rd_data[15];
                    end
                end
            end
        endcase
    end
    // frame words are quiet in the serial domain once chip select is high
    if (mode == dsrp_pkg::MD_SPI && cs_rise) begin
        next_tog_seen = tog_s2;
        if (tog_s2 != tog_seen && spi_cnt == `DSRP_FRAME_BITS) begin
            next_reg_addr = spi_sh[`DSRP_ADDR_HI:`DSRP_ADDR_LO];
            next_rb_word[`DSRP_RW_BIT] = spi_sh[`DSRP_RW_BIT];
            if (spi_sh[`DSRP_RW_BIT]) begin
                next_spi_cap = 1'b1;
            end else begin
                next_wr_en = 1'b1;
                next_wr_data = spi_sh[`DSRP_DATA_HI:0];
            end
        end
    end
    if (spi_cap) begin
        next_rb_word[22:0] = {status_low, reg_rd_data};
    end
end
always_ff @(posedge clk) begin
    if (reset) begin
        mode <= dsrp_pkg::MD_NONE;
        st <= dsrp_pkg::ST_IDLE;
        {bitcnt, shreg, hi_byte, target} <= {4'h0, 8'h00, 8'h00, `DSRP_TGT_BASE};
        {pointer, reg_addr, word, reg_wr_data} <= {7'h00, 7'h00, 16'h0000, 16'h0000};
        {is_gc, is_read, first, hi_wr, wr_pend, block, tx_lo, drive, adv} <= 9'h000;
        {reg_wr_en, sw_reset, tog_seen, spi_cap, rb_word} <= {4'h0, 24'h00_0000};
    end else begin
        mode <= next_mode;
        st <= next_st;
        {bitcnt, shreg, hi_byte, target} <= {next_bitcnt, next_shreg, next_hi_byte, next_target};
        {pointer, reg_addr, word, reg_wr_data} <= {next_pointer, next_reg_addr, next_word, next_wr_data};
        {is_gc, is_read, first, hi_wr} <= {next_is_gc, next_is_read, next_first, next_hi_wr};
        {wr_pend, block, tx_lo, drive, adv} <= {next_wr_pend, next_block, next_tx_lo, next_drive, next_adv};
        {reg_wr_en, sw_reset, spi_cap} <= {next_wr_en, next_sw_reset, next_spi_cap};
        {tog_seen, rb_word} <= {next_tog_seen, next_rb_word};
    end
end
assign sda_out = 1'b0;
assign sda_oe = drive;
assign mode_i2c = mode == dsrp_pkg::MD_I2C;
assign mode_spi = mode == dsrp_pkg::MD_SPI;
// ----------------------------------------
// assertions
// ----------------------------------------
default clocking cb @(posedge clk); endclocking
default disable iff (reset);
property p_strap; (mode != dsrp_pkg::MD_SPI && i2c_start) |=> target == dsrp_tgt($past(a1_s2), $past(a0_s2));
endproperty
a_strap: assert property (p_strap) else $error("target not from straps");
property p_addr_set; st == dsrp_pkg::ST_ADDR |-> (target & ~`DSRP_TGT_STRAP_MASK) == `DSRP_TGT_BASE; endproperty
a_addr_set: assert property (p_addr_set) else $error("target outside set");
property p_ptr_hold; $changed(pointer) |-> $past(st) == dsrp_pkg::ST_RX && $past(first) && !$past(is_gc); endproperty
a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed outside pointer byte");
property p_i2c_wr; (reg_wr_en && mode_i2c) |-> $past(st) == dsrp_pkg::ST_RXACK && $past(scl_fall) && $past(wr_pend);
endproperty
a_i2c_wr: assert property (p_i2c_wr) else $error("write before full word");
property p_blk_inc; (adv && reg_addr != `DSRP_PTR_LAST && !i2c_start) |=> reg_addr == $past(reg_addr) + 7'h01;
endproperty
a_blk_inc: assert property (p_blk_inc) else $error("block address not advanced");
property p_page_end; (adv && reg_addr == `DSRP_PTR_LAST) |=> reg_addr == `DSRP_PTR_LAST; endproperty
a_page_end: assert property (p_page_end) else $error("address left page end");
property p_gc; sw_reset |-> $past(is_gc) && $past(shreg) == `DSRP_GC_RESET; endproperty
a_gc: assert property (p_gc) else $error("reset without general call");
property p_spi_full; (reg_wr_en && mode_spi) |-> $past(cs_rise) && $past(spi_cnt) == `DSRP_FRAME_BITS; endproperty
a_spi_full: assert property (p_spi_full) else $error("short frame acted on");
property p_spi_rd; spi_cap |-> !reg_wr_en ##1 rb_word[15:0] == $past(reg_rd_data); endproperty
a_spi_rd: assert property (p_spi_rd) else $error("read frame mishandled");
property p_sdo; sdo_oe |-> !cs_n && roe_s2; endproperty
a_sdo: assert property (p_sdo) else $error("output driven while disabled");
property p_mode; mode != dsrp_pkg::MD_NONE |=> mode == $past(mode); endproperty
a_mode: assert property (p_mode) else $error("protocol changed");
c_i2c_wr: cover property (reg_wr_en && mode_i2c);
c_i2c_nack: cover property (st == dsrp_pkg::ST_TXACK && scl_rise && sda_s2);
c_gc: cover property (sw_reset);
c_spi_rd: cover property (spi_cap ##1 mode_spi);

endmodule // dsrp_port

// File: tb/dsrp_host.sv
`timescale 1ns/100ps
module dsrp_host (
    // two-wire bus
    output logic scl,
    output logic sda,
    input wire logic sda_oe,
    // four-wire bus
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic launch_rise
);
    logic sda_drv = 1'b1;
    logic sdo_line;
    // a released output floats; show the inverse so a missing drive cannot pass
    assign sdo_line = sdo_oe ? sdo_out : ~sdo_out;
    // pulled-up wire, low when either side pulls
    assign sda = sda_drv & ~sda_oe;
    initial begin
        scl = 1'b1;
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // ----------------------------------------
    // two-wire controller
    // ----------------------------------------
    // data moves 100 ns after the clock falls, so it never passes for a start or stop
    task automatic tw_bit(input logic b, output logic seen);
        sda_drv = b;
        #300;
        scl = 1'b1;
        #200;
        seen = sda;
        #200;
        scl = 1'b0;
        #100;
    endtask
    task automatic tw_start();
        sda_drv = 1'b1;
        #300;
        scl = 1'b1;
        #400;
        sda_drv = 1'b0;
        #400;
        scl = 1'b0;
        #100;
    endtask
    task automatic tw_stop();
        sda_drv = 1'b0;
        #300;
        scl = 1'b1;
        #400;
        sda_drv = 1'b1;
        #800;
    endtask
    task automatic tw_wr(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            tw_bit(b[i], s);
        end
        tw_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic tw_rd(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            tw_bit(1'b1, s);
            b[i] = s;
        end
        tw_bit(last, s);
    endtask
    // ----------------------------------------
    // four-wire controller
    // ----------------------------------------
    // clock idles low and stands still between frames
    task automatic spi_frame(input int n, input logic [31:0] w, output logic [23:0] r, output logic oe);
        r = 24'h00_0000;
        oe = 1'b0;
        #37;
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            #20;
            if (!launch_rise) r = {r[22:0], sdo_line};
            oe = oe | sdo_oe;
            sclk = 1'b1;
            #40;
            if (launch_rise) r = {r[22:0], sdo_line};
            sclk = 1'b0;
            #20;
        end
        cs_n = 1'b1;
        sdi = ~sdi;
        #700;
    endtask
endmodule // dsrp_host

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic addr_strap_low = 1'b0;
    logic addr_strap_high = 1'b0;
    logic readback_output_enable = 1'b0;
    logic output_edge_select = 1'b0;
    logic [6:0] status_low = 7'h2B;
    logic scl, sda, sda_oe, sclk, cs_n, sdi, sdo_out, sdo_oe;
    logic mode_i2c, mode_spi, sw_reset, reg_wr_en;
    logic [6:0] reg_addr;
    logic [15:0] reg_wr_data, reg_rd_data;
    logic [15:0] mem [128];
    logic [6:0] wa [$];
    logic [15:0] wd [$];
    logic [6:0] tgt;
    int sw_cnt = 0;
    int error_cnt = 0;
    int tests_run = 0;

    always #50 clk = ~clk;
    assign reg_rd_data = mem[reg_addr];

    dsrp_port i_dut (.clk(clk), .reset(reset), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .addr_strap_low(addr_strap_low), .addr_strap_high(addr_strap_high), .sclk(sclk), .cs_n(cs_n),
        .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .readback_output_enable(readback_output_enable),
        .output_edge_select(output_edge_select), .status_low(status_low), .mode_i2c(mode_i2c),
        .mode_spi(mode_spi), .sw_reset(sw_reset), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));
    dsrp_host i_host (.scl(scl), .sda(sda), .sda_oe(sda_oe), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .launch_rise(output_edge_select));

    // ----------------------------------------
    // register file model and write log
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = {1'b1, 7'(i), 8'h5A};
        end
    end
    always @(posedge clk) begin
        if (reg_wr_en === 1'b1) begin
            wa.push_back(reg_addr);
            wd.push_back(reg_wr_data);
            mem[reg_addr] <= reg_wr_data;
        end
        if (sw_reset === 1'b1) begin
            sw_cnt++;
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_wr(input int k, input logic [6:0] a, input logic [15:0] d);
        chk("write address", {17'h0_0000, a}, {17'h0_0000, wa[k]});
        chk("write data", {8'h00, d}, {8'h00, wd[k]});
    endtask
    task automatic chk_cnt(input int n);
        chk("write count", 24'(n), 24'(wa.size()));
        wa = {};
        wd = {};
    endtask
    task automatic do_reset();
        @(posedge clk) #1;
        reset = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        reset = 1'b0;
        repeat (5) @(posedge clk);
    endtask
    task automatic tw_write(input logic [6:0] dev, input logic [7:0] ptr, input int n, input logic [47:0] d,
                            output logic ack);
        logic a;
        @(posedge clk) #1;
        i_host.tw_start();
        i_host.tw_wr({dev, 1'b0}, ack);
        i_host.tw_wr(ptr, a);
        for (int k = 0; k < n; k++) begin
            i_host.tw_wr(d[47 - 8 * k -: 8], a);
        end
        i_host.tw_stop();
    endtask
    task automatic tw_read(input logic setp, input logic [7:0] ptr, input int n, output logic [47:0] got);
        logic a;
        logic [7:0] b;
        got = 48'h0000_0000_0000;
        @(posedge clk) #1;
        i_host.tw_start();
        if (setp) begin
            i_host.tw_wr({tgt, 1'b0}, a);
            i_host.tw_wr(ptr, a);
            i_host.tw_start();
        end
        i_host.tw_wr({tgt, 1'b1}, a);
        for (int k = 0; k < 2 * n; k++) begin
            i_host.tw_rd(k == 2 * n - 1, b);
            got = {got[39:0], b};
        end
        i_host.tw_stop();
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        logic ack;
        logic oe;
        logic [23:0] r;
        logic [47:0] got;
        do_reset();
        for (int s = 0; s < 4; s++) begin
            @(posedge clk) #1;
            addr_strap_low = s[0];
            addr_strap_high = s[1];
            tgt = {4'hA, s[1], 1'b0, s[0]};
            tw_write(tgt ^ 7'h01, 8'h10, 2, 48'h0000_0000_0000, ack);
            chk("foreign address ack", 24'h00_0000, {23'h00_0000, ack});
            tw_write(tgt, {1'b0, 5'h04, s[1:0]}, 2, {8'hC3, 6'h00, s[1:0], 32'h0000_0000}, ack);
            chk("address ack", 24'h00_0001, {23'h00_0000, ack});
            chk_wr(0, {5'h04, s[1:0]}, {8'hC3, 6'h00, s[1:0]});
            chk_cnt(1);
        end
        tw_write(tgt, 8'h20, 1, 48'h1100_0000_0000, ack);
        chk_cnt(0);
        tw_read(1'b1, 8'h12, 1, got);
        chk("read", 24'h00_C302, got[23:0]);
        tw_read(1'b0, 8'h00, 1, got);
        chk("reread", 24'h00_C302, got[23:0]);
        tw_write(tgt, 8'hFE, 6, 48'hA1B2_C3D4_E5F6, ack);
        chk_wr(0, 7'h7E, 16'hA1B2);
        chk_wr(1, 7'h7F, 16'hC3D4);
        chk_wr(2, 7'h7F, 16'hE5F6);
        chk_cnt(3);
        tw_read(1'b1, 8'hFE, 3, got);
        chk("block read head", 24'hA1_B2E5, got[47:24]);
        chk("block read tail", 24'hF6_E5F6, got[23:0]);
        tw_write(7'h00, 8'h06, 0, 48'h0000_0000_0000, ack);
        chk("general call ack", 24'h00_0001, {23'h00_0000, ack});
        chk("soft reset pulses", 24'h00_0001, 24'(sw_cnt));
        tw_write(7'h00, 8'h05, 0, 48'h0000_0000_0000, ack);
        chk("soft reset pulses", 24'h00_0001, 24'(sw_cnt));
        chk_cnt(0);
        chk("mode", 24'h00_0002, {22'h00_0000, mode_i2c, mode_spi});
        // four-wire needs a fresh reset: the protocol choice is sticky
        do_reset();
        i_host.spi_frame(24, 32'h0030_1234, r, oe);
        chk("mode", 24'h00_0001, {22'h00_0000, mode_i2c, mode_spi});
        chk_wr(0, 7'h30, 16'h1234);
        chk_cnt(1);
        i_host.spi_frame(23, 32'h0031_5555, r, oe);
        chk_cnt(0);
        i_host.spi_frame(28, 32'hA032_BEEF, r, oe);
        chk_wr(0, 7'h32, 16'hBEEF);
        chk_cnt(1);
        i_host.spi_frame(24, 32'h00B0_DEAD, r, oe);
        i_host.spi_frame(24, 32'h00B0_0000, r, oe);
        chk("drive while disabled", 24'h00_0000, {23'h00_0000, oe});
        chk_cnt(0);
        for (int e = 0; e < 2; e++) begin
            @(posedge clk) #1;
            readback_output_enable = 1'b1;
            output_edge_select = e[0];
            i_host.spi_frame(24, 32'h00B2_DEAD, r, oe);
            i_host.spi_frame(24, 32'h00B0_0000, r, oe);
            chk("readback", {1'b1, 7'h2B, 16'hBEEF}, r);
            chk("readback drive", 24'h00_0001, {23'h00_0000, oe});
            chk("release when deselected", 24'h00_0000, {23'h00_0000, sdo_oe});
        end
        chk_cnt(0);
        i_host.spi_frame(24, 32'h0030_4321, r, oe);
        i_host.spi_frame(24, 32'h00B0_0000, r, oe);
        chk("echo after write", 24'h00_0000, {23'h00_0000, r[23]});
        chk_cnt(1);
        summarize();
    end

    initial begin
        #2_000_000;
        error_cnt++;
        $display("mismatch watchdog expected done seen hang");
        summarize();
    end
endmodule // testbench
